// >>> rtl/cb_cfg_defs.svh
// offsets, reset values and field constants of the socket configuration header slice
`ifndef CB_CFG_DEFS_SVH
`define CB_CFG_DEFS_SVH

// byte offsets inside configuration space
`define OFF_CLASS_ID      8'h09
`define OFF_CACHE_LINE    8'h0c
`define OFF_LAT_LIMIT     8'h0d
`define OFF_HDR_TYPE      8'h0e
`define OFF_SELF_TEST     8'h0f
`define OFF_WIN_BASE      8'h10
`define OFF_EXT_START     8'h80

// dword indices derived from the byte offsets
`define DW_CLASS_ID       6'h02
`define DW_CACHE_LINE     6'h03
`define DW_WIN_BASE       6'h04

// fixed and reset values
`define CLASS_ID_VAL      24'h060700
`define HDR_TYPE_VAL      8'h82
`define SELF_TEST_VAL     8'h00
`define CACHE_LINE_RST    8'h00
`define LAT_LIMIT_RST     8'h00
`define WIN_BASE_RST      32'h00000000
`define WIN_BASE_MASK     32'hfffff000

// window layout
`define WIN_SOCKET_OFF    12'h000
`define WIN_EXCA_OFF      12'h800

`endif

// >>> rtl/cb_cfg_pkg.sv
// types for the socket configuration header slice
package cb_cfg_pkg;

    typedef struct packed {
        logic       req;
        logic       we;
        logic       func;
        logic [5:0] dw;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_cmd_t;

    typedef struct packed {
        logic        ack;
        logic        ext;
        logic [31:0] rdata;
    } cfg_rsp_t;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
    } mem_cmd_t;

    typedef struct packed {
        logic [1:0]  hit;
        logic        exca;
        logic [10:0] off;
    } mem_rsp_t;

    typedef enum logic [2:0] {
        LAT_IDLE    = 3'b001,
        LAT_RUN     = 3'b010,
        LAT_EXPIRED = 3'b100
    } lat_state_t;

    typedef struct packed {
        cfg_rsp_t              rsp;
        mem_rsp_t              mem;
        logic [1:0][7:0]       cache_line;
        logic [1:0][7:0]       lat_limit;
        logic [1:0][31:12]     win_base;
        lat_state_t            lat_st;
        logic                  lat_func;
        logic [7:0]            lat_cnt;
        logic                  lat_expired;
        logic                  mst_stop;
        logic                  gnt_n_s1;
        logic                  gnt_n_s2;
    } state_t;

endpackage

// >>> rtl/cardbus_bridge_config_header.sv
// configuration header slice 09h..13h for both socket functions, window decode, latency engine
`timescale 1ns/1ns
`include "cb_cfg_defs.svh"

// Behaviour
// - both functions report base class 06h, subclass 07h, interface 00h.
// - class identification at 09h is read-only, always 06 0700h.
// - cache line size byte is read/write, resets to zero, set by host.
// - latency limit byte at 0Dh is read/write, resets 00h, counts clocks.
// - latency counter starts from zero when the initiator asserts the frame.
// - after expiry, the own transaction ends once grant is deasserted.
// - header type byte at 0Eh is read-only and returns 82h.
// - offsets 00h..7Fh are standard header, 80h..FFh device extension.
// - self-test byte at 0Fh is read-only and returns 00h.
// - window base bits 31..12 are read/write, 4-Kbyte aligned placement.
// - window base bits 11..0 read as zero and ignore writes.
// - writing all ones to the window base reads back FFFF F000h.
// - socket registers decode from 000h, ExCA registers from 800h.
// - each function has its own independent window base register.
// - window base sits at offset 10h and resets to zero.
module cardbus_bridge_config_header (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire cb_cfg_pkg::cfg_cmd_t cfg_cmd,
    output cb_cfg_pkg::cfg_rsp_t      cfg_rsp,
    input  wire cb_cfg_pkg::mem_cmd_t mem_cmd,
    output cb_cfg_pkg::mem_rsp_t      mem_rsp,
    input  wire logic                 mst_func,
    input  wire logic                 mst_frame_start,
    input  wire logic                 mst_active,
    input  wire logic                 gnt_n_pin,
    output logic                      lat_expired,
    output logic                      mst_stop,
    output logic [1:0][7:0]           cache_line_size
);

    cb_cfg_pkg::state_t q;
    cb_cfg_pkg::state_t d;

    // read value of one configuration dword of one function
    function automatic logic [31:0] read_dw(input cb_cfg_pkg::state_t s,
                                            input logic               f,
                                            input logic [5:0]         dw);
        logic [31:0] v;
        v = 32'h00000000;
        case (dw)
            `DW_CLASS_ID:   v = {`CLASS_ID_VAL, 8'h00};
            `DW_CACHE_LINE: v = {`SELF_TEST_VAL, `HDR_TYPE_VAL, s.lat_limit[f], s.cache_line[f]};
            `DW_WIN_BASE:   v = {s.win_base[f], 12'h000} & `WIN_BASE_MASK;
            default:        v = 32'h00000000;
        endcase
        return v;
    endfunction

    // window hit; a zero base means the window is not yet placed
    function automatic logic win_hit(input logic [31:12] base, input logic [31:0] addr);
        return (base != 20'h00000) && (addr[31:12] == base);
    endfunction

    always_comb begin
        d = q;
        d.rsp.ack = 1'b0;
        d.mst_stop = 1'b0;
        d.gnt_n_s1 = gnt_n_pin;
        d.gnt_n_s2 = q.gnt_n_s1;

        if (cfg_cmd.req) begin
            d.rsp.ack = 1'b1;
            d.rsp.ext = cfg_cmd.dw[5];
            d.rsp.rdata = cfg_cmd.dw[5] ? 32'h00000000
                                        : read_dw(q, cfg_cmd.func, cfg_cmd.dw);
            if (cfg_cmd.we && !cfg_cmd.dw[5]) begin
                case (cfg_cmd.dw)
                    `DW_CACHE_LINE: begin
                        if (cfg_cmd.be[0]) begin
                            d.cache_line[cfg_cmd.func] = cfg_cmd.wdata[7:0];
                        end
                        if (cfg_cmd.be[1]) begin
                            d.lat_limit[cfg_cmd.func] = cfg_cmd.wdata[15:8];
                        end
                    end
                    `DW_WIN_BASE: begin
                        if (cfg_cmd.be[1]) begin
                            d.win_base[cfg_cmd.func][15:12] = cfg_cmd.wdata[15:12];
                        end
                        if (cfg_cmd.be[2]) begin
                            d.win_base[cfg_cmd.func][23:16] = cfg_cmd.wdata[23:16];
                        end
                        if (cfg_cmd.be[3]) begin
                            d.win_base[cfg_cmd.func][31:24] = cfg_cmd.wdata[31:24];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // socket or exca half of window
        d.mem.hit[0] = mem_cmd.req && win_hit(q.win_base[0], mem_cmd.addr);
        d.mem.hit[1] = mem_cmd.req && win_hit(q.win_base[1], mem_cmd.addr);
        d.mem.exca = mem_cmd.addr[11:0] >= `WIN_EXCA_OFF;
        d.mem.off = mem_cmd.addr[10:0];

        case (q.lat_st)
            cb_cfg_pkg::LAT_IDLE: begin
                d.lat_expired = 1'b0;
            end
            cb_cfg_pkg::LAT_RUN: begin
                if (!mst_active) begin
                    d.lat_st = cb_cfg_pkg::LAT_IDLE;
                end else if (q.lat_cnt >= q.lat_limit[q.lat_func]) begin
                    d.lat_st = cb_cfg_pkg::LAT_EXPIRED;
                    d.lat_expired = 1'b1;
                end else begin
                    d.lat_cnt = q.lat_cnt + 8'h01;
                end
            end
            cb_cfg_pkg::LAT_EXPIRED: begin
                if (!mst_active) begin
                    d.lat_st = cb_cfg_pkg::LAT_IDLE;
                    d.lat_expired = 1'b0;
                end else begin
                    d.mst_stop = q.gnt_n_s2;
                end
            end
            default: begin
                d.lat_st = cb_cfg_pkg::LAT_IDLE;
                d.lat_expired = 1'b0;
            end
        endcase

        if (mst_frame_start) begin
            d.lat_st = cb_cfg_pkg::LAT_RUN;
            d.lat_func = mst_func;
            d.lat_cnt = 8'h00;
            d.lat_expired = 1'b0;
            d.mst_stop = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q <= '0;
            q.lat_st <= cb_cfg_pkg::LAT_IDLE;
            q.gnt_n_s1 <= 1'b1;
            q.gnt_n_s2 <= 1'b1;
            for (int i = 0; i < 2; i++) begin
                q.cache_line[i] <= `CACHE_LINE_RST;
                q.lat_limit[i] <= `LAT_LIMIT_RST;
                q.win_base[i] <= 20'(`WIN_BASE_RST >> 12);
            end
        end else if (ce) begin
            q <= d;
        end
    end

    assign cfg_rsp         = q.rsp;
    assign mem_rsp         = q.mem;
    assign lat_expired     = q.lat_expired;
    assign mst_stop        = q.mst_stop;
    assign cache_line_size = q.cache_line;

endmodule // cardbus_bridge_config_header

// >>> dv/cb_cfg_properties.sv
// assertions on the configuration header slice ports
`timescale 1ns/1ns
module cb_cfg_properties (
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    input wire logic                 ce,
    input wire cb_cfg_pkg::cfg_cmd_t cfg_cmd,
    input wire cb_cfg_pkg::cfg_rsp_t cfg_rsp,
    input wire cb_cfg_pkg::mem_cmd_t mem_cmd,
    input wire cb_cfg_pkg::mem_rsp_t mem_rsp,
    input wire logic                 mst_active,
    input wire logic                 gnt_n_pin,
    input wire logic                 lat_expired,
    input wire logic                 mst_stop,
    input wire logic [1:0][7:0]      cache_line_size
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence req_s;
        rst_n && ce && cfg_cmd.req;
    endsequence
    sequence rd_s(d);
        req_s ##0 !cfg_cmd.we && cfg_cmd.dw == d;
    endsequence
    chk_ack_next: assert property (
        req_s |=> cfg_rsp.ack) else $error("no ack");
    chk_class_fixed: assert property (
        rd_s(6'h02) |=> cfg_rsp.rdata == 32'h06070000) else $error("bad class");
    chk_hdr_fixed: assert property (
        rd_s(6'h03) |=> cfg_rsp.rdata[31:16] == 16'h0082) else $error("bad header");
    chk_base_low: assert property (
        rd_s(6'h04) |=> cfg_rsp.rdata[11:0] == 12'h000) else $error("base low set");
    chk_ext_flag: assert property (
        req_s |=> cfg_rsp.ext == $past(cfg_cmd.dw[5])) else $error("bad ext");
    chk_win_off: assert property (
        rst_n && ce |=> mem_rsp.exca == $past(mem_cmd.addr[11])
            && mem_rsp.off == $past(mem_cmd.addr[10:0])) else $error("bad decode");
    chk_lat_drop: assert property (
        rst_n && ce && !mst_active |=> !lat_expired) else $error("expiry stuck");
    chk_stop_cause: assert property (
        mst_stop |-> $past(lat_expired && mst_active) && $past(gnt_n_pin, 2))
        else $error("stop without cause");
    chk_rst_clear: assert property (disable iff (1'b0)
        !rst_n |=> cache_line_size == 16'h0000 && !lat_expired && !mst_stop)
        else $error("reset left state");
endmodule // cb_cfg_properties

bind cardbus_bridge_config_header cb_cfg_properties i_chk (.core_clk, .rst_n, .ce, .cfg_cmd,
    .cfg_rsp, .mem_cmd, .mem_rsp, .mst_active, .gnt_n_pin, .lat_expired, .mst_stop,
    .cache_line_size);

// >>> dv/cb_host_model.sv
// host model issuing configuration and memory cycles
`timescale 1ns/1ns
module cb_host_model (
    input  wire logic                 core_clk,
    output cb_cfg_pkg::cfg_cmd_t      cfg_cmd,
    input  wire cb_cfg_pkg::cfg_rsp_t cfg_rsp,
    output cb_cfg_pkg::mem_cmd_t      mem_cmd,
    input  wire cb_cfg_pkg::mem_rsp_t mem_rsp
);
    initial cfg_cmd = '0;
    initial mem_cmd = '0;
    task automatic cfg(input logic we, input logic f, input logic [5:0] dw,
                       input logic [3:0] be, input logic [31:0] wd,
                       output cb_cfg_pkg::cfg_rsp_t rsp);
        @(posedge core_clk);
        cfg_cmd <= {1'b1, we, f, dw, be, wd};
        @(posedge core_clk);
        // released data flips so a stale value never passes for fresh
        cfg_cmd <= {1'b0, 1'b0, f, dw, 4'h0, ~wd};
        #1 rsp = cfg_rsp;
    endtask
    task automatic mem(input logic [31:0] a, output cb_cfg_pkg::mem_rsp_t r);
        @(posedge core_clk);
        mem_cmd <= {1'b1, a};
        @(posedge core_clk);
        mem_cmd <= {1'b0, ~a};
        #1 r = mem_rsp;
    endtask
endmodule // cb_host_model

// >>> dv/tb.sv
// self-checking bench for the configuration header slice
`timescale 1ns/1ns
module tb;
    logic                 core_clk;
    logic                 rst_n = 1'b0;
    logic                 ce = 1'b1;
    logic                 mst_func = 1'b0;
    logic                 mst_frame_start = 1'b0;
    logic                 mst_active = 1'b0;
    logic                 gnt_n_pin = 1'b1;
    logic                 lat_expired;
    logic                 mst_stop;
    logic [1:0][7:0]      cache_line_size;
    cb_cfg_pkg::cfg_cmd_t cfg_cmd;
    cb_cfg_pkg::cfg_rsp_t cfg_rsp;
    cb_cfg_pkg::mem_cmd_t mem_cmd;
    cb_cfg_pkg::mem_rsp_t mem_rsp;
    cb_cfg_pkg::cfg_rsp_t r;
    cb_cfg_pkg::mem_rsp_t m;
    int                   n_fail = 0;
    int                   check_count = 0;
    int                   cyc = 0;
    cardbus_bridge_config_header i_dut (.core_clk, .rst_n, .ce, .cfg_cmd, .cfg_rsp, .mem_cmd,
        .mem_rsp, .mst_func, .mst_frame_start, .mst_active, .gnt_n_pin, .lat_expired,
        .mst_stop, .cache_line_size);
    cb_host_model i_host (.core_clk, .cfg_cmd, .cfg_rsp, .mem_cmd, .mem_rsp);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic f, input logic [5:0] dw, input logic [31:0] e, string nm);
        i_host.cfg(1'b0, f, dw, 4'h0, 32'h0, r);
        cmp(nm, e, r.rdata);
        cmp("ack", 32'h1, {31'h0, r.ack});
    endtask
    task automatic wr(input logic f, input logic [5:0] dw, input logic [31:0] wd);
        i_host.cfg(1'b1, f, dw, 4'hf, wd, r);
    endtask
    task automatic t_reset_values();
        for (int f = 0; f < 2; f++) begin
            rd(f[0], 6'h02, 32'h06070000, "class");
            rd(f[0], 6'h03, 32'h00820000, "hdr");
            rd(f[0], 6'h04, 32'h00000000, "base");
        end
    endtask
    task automatic t_ro_rw();
        wr(1'b0, 6'h02, 32'hffffffff);
        wr(1'b0, 6'h03, 32'hffff0220);
        rd(1'b0, 6'h02, 32'h06070000, "class_wr");
        rd(1'b0, 6'h03, 32'h00820220, "hdr_wr");
        rd(1'b1, 6'h03, 32'h00820000, "hdr_f1");
        cmp("cls", 32'h0020, {16'h0, cache_line_size});
        rd(1'b0, 6'h20, 32'h0, "ext");
        cmp("ext_flag", 32'h1, {31'h0, r.ext});
    endtask
    task automatic t_window();
        wr(1'b1, 6'h04, 32'hffffffff);
        rd(1'b1, 6'h04, 32'hfffff000, "ones");
        wr(1'b0, 6'h04, 32'h12345abc);
        rd(1'b0, 6'h04, 32'h12345000, "base0");
        rd(1'b1, 6'h04, 32'hfffff000, "base1");
        i_host.mem(32'h12345804, m);
        cmp("exca", {18'h0, 2'b01, 1'b1, 11'h004}, {18'h0, m});
        i_host.mem(32'hfffff010, m);
        cmp("sock", {18'h0, 2'b10, 1'b0, 11'h010}, {18'h0, m});
    endtask
    task automatic t_latency();
        for (int g = 1; g >= 0; g--) begin
            @(posedge core_clk);
            gnt_n_pin <= g[0];
            mst_frame_start <= 1'b1;
            mst_active <= 1'b1;
            @(posedge core_clk);
            mst_frame_start <= 1'b0;
            repeat (2) @(posedge core_clk);
            #1 cmp("early", 32'h0, {31'h0, lat_expired});
            @(posedge core_clk);
            #1 cmp("expired", 32'h1, {31'h0, lat_expired});
            @(posedge core_clk);
            #1 cmp("stop", g, {31'h0, mst_stop});
            @(posedge core_clk);
            mst_active <= 1'b0;
            repeat (2) @(posedge core_clk);
            #1 cmp("cleared", 32'h0, {31'h0, lat_expired});
        end
    endtask
    // enable low must hold the latency engine idle despite a frame start
    task automatic t_freeze();
        @(posedge core_clk);
        ce <= 1'b0;
        mst_frame_start <= 1'b1;
        mst_active <= 1'b1;
        @(posedge core_clk);
        mst_frame_start <= 1'b0;
        repeat (8) @(posedge core_clk);
        #1 cmp("frozen", 32'h0, {31'h0, lat_expired});
        @(posedge core_clk);
        mst_active <= 1'b0;
        @(posedge core_clk);
        ce <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard, far above the fewer than 100 cycles used
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_ro_rw();
        t_window();
        t_latency();
        t_freeze();
        tally_and_finish();
    end
endmodule // tb
